//--- design/dual_port_mailbox_edge_mapper.sv
// Mailbox memory shared by panel and controller, with edge-watch blocks
module dual_port_mailbox_edge_mapper
  import mailbox_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input req_t req,
  output resp_t resp
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] coil_rd_reg [BIT_WORDS];   // Coils the panel reads
  logic [15:0] in_bits_reg [BIT_WORDS];   // Inputs the panel reads
  logic [15:0] in_reg_reg [REG_WORDS];    // Input registers the panel reads
  logic [15:0] hold_rd_reg [REG_WORDS];   // Holding registers the panel reads
  logic [15:0] coil_wr_reg [BIT_WORDS];   // Coils the panel wrote
  logic [15:0] hold_wr_reg [REG_WORDS];   // Holding registers the panel wrote
  logic [15:0] clr_ref_reg [BIT_WORDS];   // Last clear-block words
  logic [15:0] set_ref_reg [BIT_WORDS];   // Last set-block words
  logic [15:0] ovr_ref_reg [REG_WORDS];   // Last override words
  resp_t resp_reg;                        // Registered answer

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  hit_t hit;           // Block and index hit
  logic take;          // Request taken this edge
  logic wr;            // Write taken
  logic is_panel;      // From the panel unit
  logic ctrl_rev;      // Controller at MSB-first unit
  logic known_unit;    // One of the three mailbox units
  logic [6:0] bidx;    // Index into bit blocks
  logic [15:0] wr_nat; // Controller write in LSB-first order
  logic [15:0] rd_native; // Addressed word in stored order
  logic [15:0] fall_mask; // Clear-block bits going 1 to 0
  logic [15:0] rise_mask; // Set-block bits going 0 to 1
  logic ovr_change;    // Override word differs from last
  logic panel_bit;     // Coil value of a panel write

  region_decode u_dec (
    .req(req),
    .hit(hit)
  );

  assign take = ce && req.valid;
  assign wr = take && req.write;
  assign is_panel = (req.unit == UNIT_PANEL);
  assign ctrl_rev = (req.unit == UNIT_CTRL_REV);
  assign known_unit = is_panel || ctrl_rev || (req.unit == UNIT_CTRL_DIR);
  assign bidx = hit.idx[6:0];
  assign panel_bit = req.data[0];

  // Bits stored LSB first; MSB-first unit reverses bit blocks only
  assign wr_nat = (ctrl_rev && is_bit_region(hit.region)) ? bit_rev(req.data)
                                                           : req.data;

  // Compare against the last written word of each watch block
  always_comb begin
    fall_mask = '0;
    rise_mask = '0;
    ovr_change = 1'b0;
    if (hit.region == RG_CLR) fall_mask = clr_ref_reg[bidx] & ~wr_nat;
    if (hit.region == RG_SET) rise_mask = wr_nat & ~set_ref_reg[bidx];
    if (hit.region == RG_OVR) ovr_change = (wr_nat != ovr_ref_reg[hit.idx]);
  end

  // Read mux, word in stored order
  always_comb begin
    case (hit.region)
      RG_COIL_RD: rd_native = coil_rd_reg[bidx];
      RG_IN_BITS: rd_native = in_bits_reg[bidx];
      RG_IN_REG: rd_native = in_reg_reg[hit.idx];
      RG_HOLD_RD: rd_native = hold_rd_reg[hit.idx];
      RG_COIL_WR: rd_native = coil_wr_reg[bidx];
      RG_HOLD_WR: rd_native = hold_wr_reg[hit.idx];
      RG_CLR: rd_native = clr_ref_reg[bidx];
      RG_SET: rd_native = set_ref_reg[bidx];
      RG_OVR: rd_native = ovr_ref_reg[hit.idx];
      default: rd_native = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Controller-written readable blocks
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < BIT_WORDS; i++) begin
        coil_rd_reg[i] <= WORD_RESET;
        in_bits_reg[i] <= WORD_RESET;
      end
      for (int i = 0; i < REG_WORDS; i++) begin
        in_reg_reg[i] <= WORD_RESET;
        hold_rd_reg[i] <= WORD_RESET;
      end
    end else if (wr && !is_panel) begin
      // Panel never writes these; misses are dropped quietly
      case (hit.region)
        RG_COIL_RD: coil_rd_reg[bidx] <= wr_nat;
        RG_IN_BITS: in_bits_reg[bidx] <= wr_nat;
        RG_IN_REG: in_reg_reg[hit.idx] <= req.data;
        RG_HOLD_RD: hold_rd_reg[hit.idx] <= req.data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Panel-written coils with clear and set blocks
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < BIT_WORDS; i++) begin
        coil_wr_reg[i] <= WORD_RESET;
      end
    end else if (wr) begin
      if (is_panel && hit.region == RG_COIL_WR) begin
        coil_wr_reg[bidx][hit.bitn] <= panel_bit;
      end else if (!is_panel && hit.region == RG_CLR) begin
        coil_wr_reg[bidx] <= coil_wr_reg[bidx] & ~fall_mask;
      end else if (!is_panel && hit.region == RG_SET) begin
        coil_wr_reg[bidx] <= coil_wr_reg[bidx] | rise_mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // Panel-written holding registers with override block
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < REG_WORDS; i++) begin
        hold_wr_reg[i] <= WORD_RESET;
      end
    end else if (wr) begin
      if (is_panel && hit.region == RG_HOLD_WR) begin
        hold_wr_reg[hit.idx] <= req.data;
      end else if (!is_panel && hit.region == RG_OVR && ovr_change) begin
        hold_wr_reg[hit.idx] <= wr_nat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge-watch reference words
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < BIT_WORDS; i++) begin
        clr_ref_reg[i] <= WORD_RESET;
        set_ref_reg[i] <= WORD_RESET;
      end
      for (int i = 0; i < REG_WORDS; i++) begin
        ovr_ref_reg[i] <= WORD_RESET;
      end
    end else if (wr && !is_panel) begin
      case (hit.region)
        RG_CLR: clr_ref_reg[bidx] <= wr_nat;
        RG_SET: set_ref_reg[bidx] <= wr_nat;
        RG_OVR: ovr_ref_reg[hit.idx] <= wr_nat;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      resp_reg <= '0;
    end else if (ce) begin
      resp_reg.valid <= take && known_unit;
      resp_reg.exc <= take && (hit.region == RG_BAD);
      if (!take || req.write || hit.region == RG_BAD) begin
        resp_reg.data <= '0;
      end else if (is_panel && (hit.region == RG_COIL_RD || hit.region == RG_IN_BITS)) begin
        resp_reg.data <= {15'h0000, rd_native[hit.bitn]};
      end else if (ctrl_rev && is_bit_region(hit.region)) begin
        resp_reg.data <= bit_rev(rd_native);
      end else begin
        resp_reg.data <= rd_native;
      end
    end
  end

  assign resp = resp_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_coil_store;
    wr && is_panel && hit.region == RG_COIL_WR
      |=> coil_wr_reg[$past(bidx)][$past(hit.bitn)] == $past(panel_bit);
  endproperty
  a_coil_store: assert property (p_coil_store) else $error("panel coil not stored");

  property p_rev_read;
    take && !req.write && ctrl_rev && hit.region == RG_COIL_WR
      |=> resp.valid && resp.data == bit_rev($past(rd_native));
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("MSB-first packing wrong");

  property p_dir_read;
    take && !req.write && req.unit == UNIT_CTRL_DIR && hit.region == RG_COIL_WR
      |=> resp.valid && resp.data == $past(rd_native);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("LSB-first packing wrong");

  property p_clear;
    wr && !is_panel && hit.region == RG_CLR && fall_mask != 16'h0000
      |=> (coil_wr_reg[$past(bidx)] & $past(fall_mask)) == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("falling bit did not clear");

  property p_set;
    wr && !is_panel && hit.region == RG_SET && rise_mask != 16'h0000
      |=> (coil_wr_reg[$past(bidx)] & $past(rise_mask)) == $past(rise_mask);
  endproperty
  a_set: assert property (p_set) else $error("rising bit did not set");

  property p_hold_rd;
    take && !req.write && is_panel && hit.region == RG_HOLD_RD
      |=> resp.valid && !resp.exc && resp.data == hold_rd_reg[$past(hit.idx)];
  endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("panel holding read wrong");

  property p_hold_wr;
    wr && is_panel && hit.region == RG_HOLD_WR
      |=> hold_wr_reg[$past(hit.idx)] == $past(req.data);
  endproperty
  a_hold_wr: assert property (p_hold_wr) else $error("panel holding write lost");

  property p_override;
    wr && !is_panel && hit.region == RG_OVR && ovr_change
      |=> hold_wr_reg[$past(hit.idx)] == $past(wr_nat)
          && ovr_ref_reg[$past(hit.idx)] == $past(wr_nat);
  endproperty
  a_override: assert property (p_override) else $error("override not applied");

  property p_oob;
    take && !req.write && !is_panel && known_unit && hit.region == RG_NONE
      |=> resp.valid && !resp.exc && resp.data == 16'h0000;
  endproperty
  a_oob: assert property (p_oob) else $error("out-of-range read not zero");

  property p_ref;
    wr && !is_panel && hit.region == RG_CLR
      |=> clr_ref_reg[$past(bidx)] == $past(wr_nat) ##1 1'b1;
  endproperty
  a_ref: assert property (p_ref) else $error("clear reference not kept");

  c_clear: cover property (wr && hit.region == RG_CLR && fall_mask != 16'h0000);
  c_set: cover property (wr && hit.region == RG_SET && rise_mask != 16'h0000);
  c_override: cover property (wr && hit.region == RG_OVR && ovr_change);
  c_panel_coil: cover property (wr && is_panel && hit.region == RG_COIL_WR ##1 resp.valid);

endmodule // dual_port_mailbox_edge_mapper

//--- include/mailbox_pkg.sv
// Shared constants, types and helpers for the dual-port mailbox mapper
package mailbox_pkg;

  // ----------------------------------------------------------------
  // Unit identifiers
  // ----------------------------------------------------------------
  localparam logic [7:0] UNIT_PANEL = 8'hc8;     // Panel-side unit, 200
  localparam logic [7:0] UNIT_CTRL_REV = 8'hc9;  // Controller unit, MSB-first bits, 201
  localparam logic [7:0] UNIT_CTRL_DIR = 8'hca;  // Controller unit, LSB-first bits, 202

  // ----------------------------------------------------------------
  // Sizes and reset value
  // ----------------------------------------------------------------
  localparam int unsigned BIT_WORDS = 100;       // Words holding 1600 bits
  localparam int unsigned REG_WORDS = 512;       // Words of a register block
  localparam logic [15:0] PANEL_BITS = 16'h0640; // 1600 coils or inputs
  localparam logic [15:0] PANEL_REGS = 16'h0200; // 512 registers
  localparam logic [15:0] CTRL_BIT_WORDS = 16'h0064; // 100 packed words
  localparam logic [15:0] WORD_RESET = 16'h0000; // Power-up content

  // ----------------------------------------------------------------
  // First register number of each block (numbers as addressed)
  // ----------------------------------------------------------------
  localparam logic [15:0] BASE_PANEL = 16'h0001;   // Panel coil/register 1
  localparam logic [15:0] BASE_COIL_RD = 16'h0001; // Panel-readable coils
  localparam logic [15:0] BASE_IN_BITS = 16'h03e9; // Panel-readable inputs
  localparam logic [15:0] BASE_IN_REG = 16'h0bb9;  // Panel-readable input regs
  localparam logic [15:0] BASE_HOLD_RD = 16'h0fa1; // Panel-readable holding
  localparam logic [15:0] BASE_COIL_WR = 16'h2711; // Panel-written coils
  localparam logic [15:0] BASE_HOLD_WR = 16'h36b1; // Panel-written holding
  localparam logic [15:0] BASE_CLR = 16'h4e21;     // Clear-on-fall block
  localparam logic [15:0] BASE_OVR = 16'h5dc1;     // Overwrite-on-change block
  localparam logic [15:0] BASE_SET = 16'h7531;     // Set-on-rise block

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SP_COIL, SP_INPUT, SP_INREG, SP_HOLD} space_t;

  typedef enum logic [3:0] {
    RG_NONE, RG_COIL_RD, RG_IN_BITS, RG_IN_REG, RG_HOLD_RD, RG_COIL_WR,
    RG_HOLD_WR, RG_CLR, RG_SET, RG_OVR, RG_BAD
  } region_t;

  typedef struct packed {
    logic valid;       // Request present
    logic [7:0] unit;  // Unit identifier
    space_t space;     // Data space addressed
    logic write;       // 1 write, 0 read
    logic [15:0] addr; // Coil or register number, from 1
    logic [15:0] data; // Write data; coil value in bit 0
  } req_t;

  typedef struct packed {
    logic valid;       // Answer pulse
    logic exc;         // Illegal panel address, or controller space not holding
    logic [15:0] data; // Read data; coil value in bit 0
  } resp_t;

  typedef struct packed {
    region_t region;   // Block hit
    logic [8:0] idx;   // Word index in block
    logic [3:0] bitn;  // Bit within word, panel bit access
  } hit_t;

  // Reverse bit order of a word
  function automatic logic [15:0] bit_rev(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      bit_rev[i] = w[15 - i];
    end
  endfunction

  // Blocks that hold packed bits
  function automatic logic is_bit_region(input region_t r);
    is_bit_region = (r == RG_COIL_RD) || (r == RG_IN_BITS) || (r == RG_COIL_WR) ||
                    (r == RG_CLR) || (r == RG_SET);
  endfunction

endpackage

//--- design/region_decode.sv
// Address decoder: unit, space and number to mailbox block and index
module region_decode
  import mailbox_pkg::*;
(
  input req_t req,
  output hit_t hit
);

  // Offset into a block; bit 16 flags a hit
  function automatic logic [16:0] span(input logic [15:0] a, input logic [15:0] base,
                                       input logic [15:0] cnt);
    logic [15:0] off;
    off = a - base;
    span = {(a >= base) && (off < cnt), off};
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    logic [16:0] s;
    s = '0;
    hit.region = RG_NONE;
    hit.idx = '0;
    hit.bitn = '0;
    if (req.unit == UNIT_PANEL) begin
      // Panel: four spaces, anything else is an illegal address
      hit.region = RG_BAD;
      case (req.space)
        SP_COIL, SP_INPUT: begin
          s = span(req.addr, BASE_PANEL, PANEL_BITS);
          hit.idx = {1'b0, s[11:4]};
          hit.bitn = s[3:0];
          if (s[16] && req.space == SP_COIL) begin
            hit.region = req.write ? RG_COIL_WR : RG_COIL_RD;
          end else if (s[16] && !req.write) begin
            hit.region = RG_IN_BITS;
          end
        end
        SP_INREG: begin
          s = span(req.addr, BASE_PANEL, PANEL_REGS);
          hit.idx = s[8:0];
          if (s[16] && !req.write) hit.region = RG_IN_REG;
        end
        SP_HOLD: begin
          s = span(req.addr, BASE_PANEL, PANEL_REGS);
          hit.idx = s[8:0];
          if (s[16]) hit.region = req.write ? RG_HOLD_WR : RG_HOLD_RD;
        end
        default: hit.region = RG_BAD;
      endcase
    end else if (req.unit == UNIT_CTRL_REV || req.unit == UNIT_CTRL_DIR) begin
      // Controller: holding space only; unmatched numbers fall to none
      if (req.space != SP_HOLD) begin
        hit.region = RG_BAD;
      end else if (span(req.addr, BASE_COIL_RD, CTRL_BIT_WORDS) >= 17'h10000) begin
        hit.region = RG_COIL_RD;
        hit.idx = 9'(req.addr - BASE_COIL_RD);
      end else if (span(req.addr, BASE_IN_BITS, CTRL_BIT_WORDS) >= 17'h10000) begin
        hit.region = RG_IN_BITS;
        hit.idx = 9'(req.addr - BASE_IN_BITS);
      end else if (span(req.addr, BASE_IN_REG, PANEL_REGS) >= 17'h10000) begin
        hit.region = RG_IN_REG;
        hit.idx = 9'(req.addr - BASE_IN_REG);
      end else if (span(req.addr, BASE_HOLD_RD, PANEL_REGS) >= 17'h10000) begin
        hit.region = RG_HOLD_RD;
        hit.idx = 9'(req.addr - BASE_HOLD_RD);
      end else if (span(req.addr, BASE_COIL_WR, CTRL_BIT_WORDS) >= 17'h10000) begin
        hit.region = RG_COIL_WR;
        hit.idx = 9'(req.addr - BASE_COIL_WR);
      end else if (span(req.addr, BASE_HOLD_WR, PANEL_REGS) >= 17'h10000) begin
        hit.region = RG_HOLD_WR;
        hit.idx = 9'(req.addr - BASE_HOLD_WR);
      end else if (span(req.addr, BASE_CLR, CTRL_BIT_WORDS) >= 17'h10000) begin
        hit.region = RG_CLR;
        hit.idx = 9'(req.addr - BASE_CLR);
      end else if (span(req.addr, BASE_OVR, PANEL_REGS) >= 17'h10000) begin
        hit.region = RG_OVR;
        hit.idx = 9'(req.addr - BASE_OVR);
      end else if (span(req.addr, BASE_SET, CTRL_BIT_WORDS) >= 17'h10000) begin
        hit.region = RG_SET;
        hit.idx = 9'(req.addr - BASE_SET);
      end
    end
  end

endmodule // region_decode

//--- verif/mailbox_master_model.sv
// Behavioural request master standing in for the panel and the controller
module mailbox_master_model
  import mailbox_pkg::*;
(
  input wire logic sys_clk,
  output req_t req,
  input resp_t resp
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle request at time zero
  initial begin
    req = '0;
  end

  // ----------------------------------------------------------------
  // One transfer
  // ----------------------------------------------------------------
  // Present at a falling edge, hold through the taking edge, then await the answer
  task automatic xfer(input logic [7:0] unit, input space_t sp, input logic wr,
                      input logic [15:0] addr, input logic [15:0] dat,
                      output resp_t r, output bit ok);
    ok = 1'b0;
    r = '0;
    @(negedge sys_clk);
    req = '{valid: 1'b1, unit: unit, space: sp, write: wr, addr: addr, data: dat};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge sys_clk);
      if (i == 0) begin
        // Released lines no longer show the last value
        req.valid = 1'b0;
        req.addr = ~addr;
        req.data = ~dat;
      end
      if (resp.valid === 1'b1) begin
        r = resp;
        ok = 1'b1;
      end
    end
  endtask
endmodule // mailbox_master_model

//--- verif/dual_port_mailbox_edge_mapper_tb.sv
// Self-checking bench for the dual-port mailbox mapper
module dual_port_mailbox_edge_mapper_tb import mailbox_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk; // Bench clock, 8 ns
  logic resetn; // Active-low reset
  logic ce; // Clock enable
  req_t req; // Request from the master model
  resp_t resp; // Answer from the mailbox
  int err_count; // Mismatches seen
  int samples_checked; // Comparisons made

  dual_port_mailbox_edge_mapper dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .req(req), .resp(resp));
  mailbox_master_model mstr (.sys_clk(sys_clk), .req(req), .resp(resp));

  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bounded transfer; a missing answer ends the run
  task automatic acc(input logic [7:0] u, input space_t sp, input logic w,
                     input logic [15:0] a, input logic [15:0] d, output resp_t r);
    bit ok;
    mstr.xfer(u, sp, w, a, d, r, ok);
    if (!ok) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] u, input space_t sp, input logic [15:0] a,
                    input logic [15:0] d);
    resp_t r;
    acc(u, sp, 1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] u, input space_t sp, input logic [15:0] a,
                    input logic [15:0] e);
    resp_t r;
    acc(u, sp, 1'b0, a, 16'h0000, r);
    check(r.data, e);
  endtask

  // Reset held three cycles, released at a falling edge
  task automatic do_reset();
    resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_coils();
    wr(UNIT_PANEL, SP_COIL, 16'h00c9, 16'h0001);
    wr(UNIT_PANEL, SP_COIL, 16'h0021, 16'h0001);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h271d, 16'h0080);
    rd(UNIT_CTRL_DIR, SP_HOLD, 16'h271d, 16'h0100);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h2713, 16'h8000);
    rd(UNIT_CTRL_DIR, SP_HOLD, 16'h2713, 16'h0001);
    rd(UNIT_PANEL, SP_COIL, 16'h00c9, 16'h0000);
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h03e9, 16'h8000);
    rd(UNIT_PANEL, SP_INPUT, 16'h0001, 16'h0001);
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h0bb9, 16'h5a5a);
    rd(UNIT_PANEL, SP_INREG, 16'h0001, 16'h5a5a);
    $display("test coils done");
  endtask

  task automatic t_clear();
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h4e2d, 16'h0080);
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h4e2d, 16'h0080);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h271d, 16'h0080);
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h4e2d, 16'h0000);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h271d, 16'h0000);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h2713, 16'h8000);
    $display("test clear done");
  endtask

  task automatic t_set();
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h753d, 16'h0080);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h271d, 16'h0080);
    wr(UNIT_CTRL_DIR, SP_HOLD, 16'h7533, 16'h0002);
    rd(UNIT_CTRL_DIR, SP_HOLD, 16'h2713, 16'h0003);
    $display("test set done");
  endtask

  task automatic t_regs();
    wr(UNIT_CTRL_DIR, SP_HOLD, 16'h0fa1, 16'h1234);
    rd(UNIT_PANEL, SP_HOLD, 16'h0001, 16'h1234);
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h11a0, 16'ha5c3);
    rd(UNIT_PANEL, SP_HOLD, 16'h0200, 16'ha5c3);
    wr(UNIT_PANEL, SP_HOLD, 16'h0065, 16'hbeef);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h3715, 16'hbeef);
    rd(UNIT_CTRL_DIR, SP_HOLD, 16'h3715, 16'hbeef);
    rd(UNIT_PANEL, SP_HOLD, 16'h0065, 16'h0000);
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h1005, 16'hbeef);
    rd(UNIT_PANEL, SP_HOLD, 16'h0065, 16'hbeef);
    $display("test registers done");
  endtask

  task automatic t_override();
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h5e25, 16'h0005);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h3715, 16'h0005);
    wr(UNIT_PANEL, SP_HOLD, 16'h0065, 16'h0009);
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h5e25, 16'h0005);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h3715, 16'h0009);
    wr(UNIT_CTRL_DIR, SP_HOLD, 16'h5e25, 16'h0000);
    rd(UNIT_CTRL_DIR, SP_HOLD, 16'h3715, 16'h0000);
    $display("test override done");
  endtask

  task automatic t_range();
    resp_t r;
    acc(UNIT_CTRL_REV, SP_HOLD, 1'b1, 16'h270f, 16'h5555, r);
    check({15'h0000, r.exc}, 16'h0000);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h270f, 16'h0000);
    rd(UNIT_CTRL_DIR, SP_HOLD, 16'h270f, 16'h0000);
    $display("test range done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    err_count = 0;
    samples_checked = 0;
    do_reset();
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h271d, 16'h0000);
    rd(UNIT_PANEL, SP_HOLD, 16'h0065, 16'h0000);
    t_coils();
    t_clear();
    t_set();
    t_regs();
    t_override();
    t_range();
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h5e25, 16'h0007); // Non-zero override reference
    do_reset();
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h2713, 16'h0000);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h3715, 16'h0000);
    wr(UNIT_PANEL, SP_HOLD, 16'h0065, 16'h0009);
    wr(UNIT_CTRL_REV, SP_HOLD, 16'h5e25, 16'h0007);
    rd(UNIT_CTRL_REV, SP_HOLD, 16'h3715, 16'h0007);
    $display("test second reset done");
    end_of_test();
  end
endmodule // dual_port_mailbox_edge_mapper_tb
